// File: logic/pcr_defs.svh
// Index, field and reset constants of the card configuration registers
`ifndef PCR_DEFS_SVH
`define PCR_DEFS_SVH
// ---------------------------------------------------------------
// Register indices
// ---------------------------------------------------------------
`define PCR_IDX_RDPORT    8'h00
`define PCR_IDX_CFGCTL    8'h02
`define PCR_IDX_WAKE      8'h03
`define PCR_IDX_RES       8'h04
`define PCR_IDX_STAT      8'h05
`define PCR_IDX_CSN       8'h06
`define PCR_IDX_LDN       8'h07
`define PCR_IDX_ACT       8'h30
`define PCR_IDX_RCHK      8'h31
`define PCR_IDX_PWR       8'h38
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PCR_CTL_RST_BIT   0
`define PCR_CTL_WFK_BIT   1
`define PCR_CTL_CSN0_BIT  2
`define PCR_RCHK_SEL_BIT  0
`define PCR_RCHK_EN_BIT   1
// ---------------------------------------------------------------
// Values and reset values
// ---------------------------------------------------------------
`define PCR_CSN_NONE      8'h00
`define PCR_LDN_VAL       8'h00
`define PCR_PAT_SEL0      8'hAA
`define PCR_PAT_SEL1      8'h55
`define PCR_ACT_RST       1'b0
`define PCR_RCHK_RST      2'h0
`define PCR_PWR_RST       8'h00
`define PCR_RDATA_RST     8'h00
`endif

// File: logic/pcr_pkg.sv
// Types shared by the card configuration register logic
package pcr_pkg;
	// Card configuration states
	typedef enum logic [1:0] {
		PCR_WAIT_KEY = 2'b00,
		PCR_SLEEP    = 2'b01,
		PCR_ISOLATE  = 2'b10,
		PCR_CONFIG   = 2'b11
	} pcr_state_t;
endpackage : pcr_pkg

// File: logic/pcr_pdr_store.sv
// Power-down byte shared by the direct and indirect register paths
`timescale 1ns/1ps
`include "pcr_defs.svh"
module pcr_pdr_store (
	// Clock, reset, enable
	input  wire logic       core_clk_i,
	input  wire logic       rstn_i,
	input  wire logic       ce_i,
	// Configuration path
	input  wire logic       clear_i,
	input  wire logic       cfg_we_i,
	input  wire logic [7:0] cfg_d_i,
	// Indirect register path
	input  wire logic       ind_we_i,
	input  wire logic [7:0] ind_d_i,
	// Stored value
	output logic      [7:0] pdr_o
);
	// One byte, two writers; a soft reset beats both
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pdr_o <= `PCR_PWR_RST;
		end else if (ce_i) begin
			if (clear_i) begin
				pdr_o <= `PCR_PWR_RST;
			end else if (cfg_we_i) begin
				pdr_o <= cfg_d_i;
			end else if (ind_we_i) begin
				pdr_o <= ind_d_i;
			end
		end
	end
endmodule : pcr_pdr_store

// File: logic/pcr_res_reader.sv
// Resource byte fetcher with auto-increment pointer and ready flag
`timescale 1ns/1ps
module pcr_res_reader #(
	parameter int PTR_W = 12
)(
	// Clock, reset, enable
	input  wire logic             core_clk_i,
	input  wire logic             rstn_i,
	input  wire logic             ce_i,
	// Control from the register bank
	input  wire logic             restart_i,
	input  wire logic             next_i,
	output logic      [7:0]       byte_o,
	output logic                  ready_o,
	// External resource storage
	output logic      [PTR_W-1:0] rom_addr_o,
	output logic                  rom_req_o,
	input  wire logic             rom_ack_i,
	input  wire logic [7:0]       rom_data_i
);
	logic       ack_s1_q;
	logic       ack_s2_q;
	logic [7:0] dat_s1_q;
	logic [7:0] dat_s2_q;
	logic       pend_q;

	// Two-stage capture of the storage answer
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
			dat_s1_q <= 8'h00;
			dat_s2_q <= 8'h00;
		end else if (ce_i) begin
			ack_s1_q <= rom_ack_i;
			ack_s2_q <= ack_s1_q;
			dat_s1_q <= rom_data_i;
			dat_s2_q <= dat_s1_q;
		end
	end

	// Four-phase fetch; stale answers after a restart are dropped
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rom_addr_o <= '0;
			rom_req_o  <= 1'b0;
			ready_o    <= 1'b0;
			byte_o     <= 8'h00;
			pend_q     <= 1'b1;
		end else if (ce_i) begin
			if (restart_i || (next_i && ready_o)) begin
				rom_addr_o <= restart_i ? '0 : rom_addr_o + 1'b1;
				ready_o    <= 1'b0;
				pend_q     <= 1'b1;
			end else if (rom_req_o && ack_s2_q) begin
				rom_req_o <= 1'b0;
				if (!pend_q) begin
					byte_o  <= dat_s2_q;
					ready_o <= 1'b1;
				end
			end else if (!rom_req_o && !ack_s2_q && pend_q) begin
				rom_req_o <= 1'b1;
				pend_q    <= 1'b0;
			end
		end
	end
endmodule : pcr_res_reader

// File: logic/pcr_top.sv
// Plug and Play card configuration register bank, top level
//
// Operation
// - Wake value zero in sleep without card number enters isolation.
// - Wake value equal to assigned card number enters configure.
// - Nonzero wake value not matching card number goes to sleep.
// - Wake value zero in configure returns to sleep.
// - Resource read with status bit 0 high returns byte at pointer, then advances pointer.
// - Status bit 0 high only when next resource byte available.
// - Writing 01h to FFh to card number stores a valid number.
// - Card number zero means no number assigned.
// - Logical device number reads zero, writes ignored.
// - Activate bit enables bus; when low only configuration and range check answer.
// - Activate bit cleared by reset and by control reset bit.
// - Range check enable makes configured I/O reads return pattern.
// - Pattern select zero gives AAh, one gives 55h.
// - Reserved bits of activate and range check read zero.
// - Power management byte is shared with indirect power-down byte.
// - Registers readable only in configure state; isolation accepts the sleep writes plus card number writes.
// - Sleep accepts only wake, control and read-port writes.
// - Control reset bit restores defaults, keeps card number.
`timescale 1ns/1ps
`include "pcr_defs.svh"
module pcr_top
	import pcr_pkg::*;
#(
	parameter int PTR_W = 12
)(
	// Clock, reset, enable
	input  wire logic             core_clk_i,
	input  wire logic             rstn_i,
	input  wire logic             ce_i,
	// Configuration port strobes from the bus front end
	input  wire logic             cfg_addr_wr_i,
	input  wire logic             cfg_data_wr_i,
	input  wire logic             cfg_data_rd_i,
	input  wire logic [7:0]       cfg_wdata_i,
	output logic      [7:0]       cfg_rdata_o,
	// Events from key and isolation logic
	input  wire logic             key_ok_i,
	input  wire logic             iso_lost_i,
	// Indirect power-down path
	input  wire logic             ind_pdr_we_i,
	input  wire logic [7:0]       ind_pdr_d_i,
	output logic      [7:0]       power_down_register_o,
	// Device I/O range reads
	input  wire logic             io_rd_i,
	input  wire logic [7:0]       io_data_i,
	output logic      [7:0]       io_data_o,
	output logic                  io_drive_o,
	// Status
	output pcr_state_t            state_o,
	output logic      [7:0]       card_select_number_o,
	output logic                  activate_o,
	// External resource storage
	output logic      [PTR_W-1:0] rom_addr_o,
	output logic                  rom_req_o,
	input  wire logic             rom_ack_i,
	input  wire logic [7:0]       rom_data_i
);
	// ---------------------------------------------------------------
	// Storage and decode
	// ---------------------------------------------------------------
	logic [7:0] idx_q;
	logic [1:0] rchk_q;
	logic       wr_ok;
	logic       rd_ok;
	logic       soft_rst;
	logic       res_next;
	logic       res_restart;
	logic [7:0] res_byte;
	logic       res_ready;
	logic [7:0] rd_mux;
	logic [7:0] pattern;

	// Which accesses a state admits
	function automatic logic pcr_access_ok(pcr_state_t s, logic [7:0] idx,
			logic is_wr);
		logic sleep_ok;
		sleep_ok = (idx == `PCR_IDX_WAKE) || (idx == `PCR_IDX_CFGCTL) ||
			(idx == `PCR_IDX_RDPORT);
		unique case (s)
			PCR_WAIT_KEY: pcr_access_ok = 1'b0;
			PCR_SLEEP:    pcr_access_ok = is_wr && sleep_ok;
			PCR_ISOLATE:  pcr_access_ok = is_wr &&
				(sleep_ok || idx == `PCR_IDX_CSN);
			PCR_CONFIG:   pcr_access_ok = 1'b1;
		endcase
	endfunction : pcr_access_ok

	assign wr_ok = ce_i && cfg_data_wr_i &&
		pcr_access_ok(state_o, idx_q, 1'b1);
	assign rd_ok = ce_i && cfg_data_rd_i &&
		pcr_access_ok(state_o, idx_q, 1'b0);

	assign soft_rst = wr_ok && (idx_q == `PCR_IDX_CFGCTL) &&
		cfg_wdata_i[`PCR_CTL_RST_BIT];

	assign res_next    = rd_ok && (idx_q == `PCR_IDX_RES) && res_ready;
	assign res_restart = wr_ok && (idx_q == `PCR_IDX_WAKE);

	assign pattern = rchk_q[`PCR_RCHK_SEL_BIT] ? `PCR_PAT_SEL1 :
		`PCR_PAT_SEL0;

	// ---------------------------------------------------------------
	// Index register
	// ---------------------------------------------------------------
	// index selects the target
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			idx_q <= `PCR_IDX_RDPORT;
		end else if (ce_i && cfg_addr_wr_i) begin
			idx_q <= cfg_wdata_i;
		end
	end

	// ---------------------------------------------------------------
	// Card state machine
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_o <= PCR_WAIT_KEY;
		end else if (ce_i) begin
			if (wr_ok && idx_q == `PCR_IDX_CFGCTL &&
					cfg_wdata_i[`PCR_CTL_WFK_BIT]) begin
				state_o <= PCR_WAIT_KEY;
			end else if (wr_ok && idx_q == `PCR_IDX_WAKE) begin
				if (cfg_wdata_i == `PCR_CSN_NONE) begin
					if (state_o == PCR_SLEEP &&
							card_select_number_o == `PCR_CSN_NONE) begin
						state_o <= PCR_ISOLATE;
					end else if (state_o == PCR_CONFIG) begin
						state_o <= PCR_SLEEP;
					end
				end else if (cfg_wdata_i == card_select_number_o) begin
					state_o <= PCR_CONFIG;
				end else begin
					state_o <= PCR_SLEEP;
				end
			end else if (wr_ok && idx_q == `PCR_IDX_CSN &&
					state_o == PCR_ISOLATE &&
					cfg_wdata_i != `PCR_CSN_NONE) begin
				// Number assignment ends isolation
				state_o <= PCR_CONFIG;
			end else if (state_o == PCR_WAIT_KEY && key_ok_i) begin
				state_o <= PCR_SLEEP;
			end else if (state_o == PCR_ISOLATE && iso_lost_i) begin
				state_o <= PCR_SLEEP;
			end
		end
	end

	// ---------------------------------------------------------------
	// Card select number
	// ---------------------------------------------------------------
	// store assigned number
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			card_select_number_o <= `PCR_CSN_NONE;
		end else if (ce_i) begin
			if (wr_ok && idx_q == `PCR_IDX_CFGCTL &&
					cfg_wdata_i[`PCR_CTL_CSN0_BIT]) begin
				card_select_number_o <= `PCR_CSN_NONE;
			end else if (wr_ok && idx_q == `PCR_IDX_CSN) begin
				card_select_number_o <= cfg_wdata_i;
			end
		end
	end

	// ---------------------------------------------------------------
	// Activate and range check
	// ---------------------------------------------------------------
	// activate clear on reset bit
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			activate_o <= `PCR_ACT_RST;
			rchk_q     <= `PCR_RCHK_RST;
		end else if (ce_i) begin
			if (soft_rst) begin
				activate_o <= `PCR_ACT_RST;
				rchk_q     <= `PCR_RCHK_RST;
			end else if (wr_ok && idx_q == `PCR_IDX_ACT) begin
				activate_o <= cfg_wdata_i[0];
			end else if (wr_ok && idx_q == `PCR_IDX_RCHK) begin
				rchk_q <= cfg_wdata_i[1:0];
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			io_drive_o <= 1'b0;
			io_data_o  <= 8'h00;
		end else if (ce_i) begin
			io_drive_o <= io_rd_i &&
				(activate_o || rchk_q[`PCR_RCHK_EN_BIT]);
			io_data_o  <= rchk_q[`PCR_RCHK_EN_BIT] ? pattern : io_data_i;
		end
	end

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	// fixed logical device number
	always_comb begin
		unique case (idx_q)
			`PCR_IDX_RES:  rd_mux = res_byte;
			`PCR_IDX_STAT: rd_mux = {7'h00, res_ready};
			`PCR_IDX_CSN:  rd_mux = card_select_number_o;
			`PCR_IDX_LDN:  rd_mux = `PCR_LDN_VAL;
			`PCR_IDX_ACT:  rd_mux = {7'h00, activate_o};
			`PCR_IDX_RCHK: rd_mux = {6'h00, rchk_q};
			`PCR_IDX_PWR:  rd_mux = power_down_register_o;
			default:       rd_mux = `PCR_RDATA_RST;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg_rdata_o <= `PCR_RDATA_RST;
		end else if (ce_i && cfg_data_rd_i) begin
			cfg_rdata_o <= rd_ok ? rd_mux : `PCR_RDATA_RST;
		end
	end

	// ---------------------------------------------------------------
	// Submodules
	// ---------------------------------------------------------------
	pcr_res_reader #(
		.PTR_W      (PTR_W)
	) u_res (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.ce_i       (ce_i),
		.restart_i  (res_restart),
		.next_i     (res_next),
		.byte_o     (res_byte),
		.ready_o    (res_ready),
		.rom_addr_o (rom_addr_o),
		.rom_req_o  (rom_req_o),
		.rom_ack_i  (rom_ack_i),
		.rom_data_i (rom_data_i)
	);

	pcr_pdr_store u_pdr (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.ce_i       (ce_i),
		.clear_i    (soft_rst),
		.cfg_we_i   (wr_ok && idx_q == `PCR_IDX_PWR),
		.cfg_d_i    (cfg_wdata_i),
		.ind_we_i   (ce_i && ind_pdr_we_i),
		.ind_d_i    (ind_pdr_d_i),
		.pdr_o      (power_down_register_o)
	);

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_wake_wr;
		wr_ok && idx_q == `PCR_IDX_WAKE;
	endsequence
	sequence s_res_read;
		rd_ok && idx_q == `PCR_IDX_RES && res_ready;
	endsequence

	property p_wake_iso;
		s_wake_wr and (cfg_wdata_i == 8'h00 && state_o == PCR_SLEEP &&
			card_select_number_o == 8'h00) |=> state_o == PCR_ISOLATE;
	endproperty
	a_wake_iso: assert property (p_wake_iso)
		else $error("zero wake did not isolate");

	property p_wake_match;
		s_wake_wr and (cfg_wdata_i != 8'h00 &&
			cfg_wdata_i == card_select_number_o) |=> state_o == PCR_CONFIG;
	endproperty
	a_wake_match: assert property (p_wake_match)
		else $error("matching wake did not configure");

	property p_wake_miss;
		s_wake_wr and (cfg_wdata_i != 8'h00 &&
			cfg_wdata_i != card_select_number_o) |=> state_o == PCR_SLEEP;
	endproperty
	a_wake_miss: assert property (p_wake_miss)
		else $error("mismatching wake did not sleep");

	property p_wake_cfg;
		s_wake_wr and (cfg_wdata_i == 8'h00 && state_o == PCR_CONFIG)
			|=> state_o == PCR_SLEEP;
	endproperty
	a_wake_cfg: assert property (p_wake_cfg)
		else $error("zero wake did not leave configure");

	property p_res_step;
		s_res_read |=> !res_ready &&
			rom_addr_o == $past(rom_addr_o) + 1'b1;
	endproperty
	a_res_step: assert property (p_res_step)
		else $error("resource pointer did not advance");

	property p_stat_read;
		rd_ok && idx_q == `PCR_IDX_STAT |=>
			cfg_rdata_o == {7'h00, $past(res_ready)};
	endproperty
	a_stat_read: assert property (p_stat_read)
		else $error("status read mismatch");

	property p_ldn_zero;
		rd_ok && idx_q == `PCR_IDX_LDN |=> cfg_rdata_o == 8'h00;
	endproperty
	a_ldn_zero: assert property (p_ldn_zero)
		else $error("logical device number not zero");

	property p_act_clr;
		soft_rst |=> !activate_o && rchk_q == 2'h0;
	endproperty
	a_act_clr: assert property (p_act_clr)
		else $error("control reset left activate set");

	property p_pattern;
		ce_i && io_rd_i && rchk_q[1] |=>
			io_drive_o && io_data_o == ($past(rchk_q[0]) ? 8'h55 : 8'hAA);
	endproperty
	a_pattern: assert property (p_pattern)
		else $error("range check pattern wrong");

	property p_sleep_guard;
		state_o == PCR_SLEEP && ce_i && cfg_data_wr_i &&
			idx_q == `PCR_IDX_ACT |=> $stable(activate_o);
	endproperty
	a_sleep_guard: assert property (p_sleep_guard)
		else $error("sleep state accepted a register write");

	property p_pdr_alias;
		ce_i && ind_pdr_we_i && !(wr_ok && idx_q == `PCR_IDX_PWR) &&
			!soft_rst |=> power_down_register_o == $past(ind_pdr_d_i);
	endproperty
	a_pdr_alias: assert property (p_pdr_alias)
		else $error("indirect write not visible");
endmodule : pcr_top

// File: test/pcr_rom_model.sv
// Resource storage model answering the four-phase fetch handshake
`timescale 1ns/1ps
module pcr_rom_model (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rstn_i,
	// Fetch request from the register bank
	input  wire logic [11:0] rom_addr_i,
	input  wire logic        rom_req_i,
	// Answer delay in cycles, set by the bench
	input  wire logic [3:0]  delay_i,
	// Answer
	output logic             rom_ack_o,
	output logic      [7:0]  rom_data_o
);
	logic [3:0] cnt_q;

	// Content of the storage, one byte per pointer value
	function automatic logic [7:0] rom_byte(input logic [11:0] a);
		return a[7:0] ^ 8'hA5;
	endfunction : rom_byte

	// Handshake: wait, present byte with ack, drop ack after req falls
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rom_ack_o  <= 1'b0;
			rom_data_o <= 8'h00;
			cnt_q      <= 4'h0;
		end else if (rom_req_i && !rom_ack_o) begin
			if (cnt_q >= delay_i) begin
				rom_ack_o  <= 1'b1;
				rom_data_o <= rom_byte(rom_addr_i);
				cnt_q      <= 4'h0;
			end else begin
				cnt_q      <= cnt_q + 4'h1;
				rom_data_o <= ~rom_data_o;
			end
		end else if (!rom_ack_o || !rom_req_i) begin
			// Data not held once ack is gone
			rom_ack_o  <= 1'b0;
			rom_data_o <= ~rom_data_o;
			cnt_q      <= 4'h0;
		end
	end
endmodule : pcr_rom_model

// File: test/tb_top.sv
// Self-checking testbench of the card configuration register bank
`timescale 1ns/1ps
module tb_top
	import pcr_pkg::*;
;
	logic        core_clk, rstn, addr_wr, data_wr, data_rd;
	logic        key_ok, iso_lost, ind_we, io_rd, io_drive;
	logic        act, rom_req, rom_ack;
	logic [7:0]  wdata, rdata, ind_d, pdr, io_din, io_dout;
	logic [7:0]  card_select_value, rom_data;
	logic [11:0] rom_addr;
	logic [3:0]  rom_delay;
	pcr_state_t  state;
	int          err_count, total_checks, ptr;

	pcr_top #(.PTR_W(12)) pcr_top_i (
		.core_clk_i(core_clk), .rstn_i(rstn), .ce_i(1'b1),
		.cfg_addr_wr_i(addr_wr), .cfg_data_wr_i(data_wr),
		.cfg_data_rd_i(data_rd), .cfg_wdata_i(wdata),
		.cfg_rdata_o(rdata), .key_ok_i(key_ok), .iso_lost_i(iso_lost),
		.ind_pdr_we_i(ind_we), .ind_pdr_d_i(ind_d),
		.power_down_register_o(pdr), .io_rd_i(io_rd),
		.io_data_i(io_din), .io_data_o(io_dout), .io_drive_o(io_drive),
		.state_o(state), .card_select_number_o(card_select_value), .activate_o(act),
		.rom_addr_o(rom_addr), .rom_req_o(rom_req),
		.rom_ack_i(rom_ack), .rom_data_i(rom_data));

	pcr_rom_model pcr_rom_model_i (
		.core_clk_i(core_clk), .rstn_i(rstn), .rom_addr_i(rom_addr),
		.rom_req_i(rom_req), .delay_i(rom_delay),
		.rom_ack_o(rom_ack), .rom_data_o(rom_data));

	// Clock generator
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] e,
			input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic step;
		@(posedge core_clk);
		#1;
	endtask : step

	// index to the address port, then value to the data port
	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
		step;
		addr_wr = 1'b1;
		wdata = idx;
		step;
		addr_wr = 1'b0;
		data_wr = 1'b1;
		wdata = val;
		step;
		data_wr = 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
		step;
		addr_wr = 1'b1;
		wdata = idx;
		step;
		addr_wr = 1'b0;
		data_rd = 1'b1;
		step;
		data_rd = 1'b0;
		step;
		d = rdata;
	endtask : reg_rd

	task automatic chk_rd(input logic [7:0] idx, input logic [7:0] e,
			input string n);
		logic [7:0] d;
		reg_rd(idx, d);
		chk(n, e, d);
	endtask : chk_rd

	task automatic io_check(input logic [7:0] e, input logic drv,
			input string n);
		step;
		io_rd = 1'b1;
		io_din = 8'h3C;
		step;
		io_rd = 1'b0;
		chk({n, "_drive"}, {7'h00, drv}, {7'h00, io_drive});
		if (drv)
			chk(n, e, io_dout);
	endtask : io_check

	// Poll ready, then take one resource byte
	task automatic res_get;
		int n;
		logic [7:0] s;
		n = 0;
		s = 8'h00;
		while (s[0] !== 1'b1 && n < 300) begin
			reg_rd(8'h05, s);
			n++;
		end
		chk("status", 8'h01, s);
		if (s !== 8'h01) begin
			final_report;
		end else begin
			chk_rd(8'h04, ptr[7:0] ^ 8'hA5, "resource");
			ptr++;
		end
	endtask : res_get

	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic sc_reset;
		chk("state", 8'h00, {6'h00, state});
		chk("csn_rst", 8'h00, card_select_value);
		chk("act_rst", 8'h00, {7'h00, act});
		chk("pdr_rst", 8'h00, pdr);
	endtask : sc_reset

	task automatic sc_sleep;
		step;
		key_ok = 1'b1;
		step;
		key_ok = 1'b0;
		chk("state_sleep", 8'h01, {6'h00, state});
		reg_wr(8'h06, 8'h09);
		chk("csn_sleep", 8'h00, card_select_value);
		chk_rd(8'h06, 8'h00, "rd_sleep");
		reg_wr(8'h30, 8'h01);
		chk("act_sleep", 8'h00, {7'h00, act});
	endtask : sc_sleep

	task automatic sc_isolate;
		reg_wr(8'h03, 8'h00);
		chk("state_iso", 8'h02, {6'h00, state});
		step;
		iso_lost = 1'b1;
		step;
		iso_lost = 1'b0;
		chk("state_lost", 8'h01, {6'h00, state});
		reg_wr(8'h03, 8'h00);
		reg_wr(8'h06, 8'hFF);
		chk("csn_ff", 8'hFF, card_select_value);
		chk("state_cfg", 8'h03, {6'h00, state});
		reg_wr(8'h06, 8'h01);
		chk_rd(8'h06, 8'h01, "csn_01");
	endtask : sc_isolate

	task automatic sc_wake;
		logic [7:0] wv[6];
		logic [7:0] es[6];
		wv = '{8'h00, 8'h02, 8'h01, 8'h80, 8'h00, 8'h01};
		es = '{8'h01, 8'h01, 8'h03, 8'h01, 8'h01, 8'h03};
		for (int i = 0; i < 6; i++) begin
			reg_wr(8'h03, wv[i]);
			chk("state_wake", es[i], {6'h00, state});
		end
	endtask : sc_wake

	task automatic sc_regs;
		reg_wr(8'h07, 8'h33);
		chk_rd(8'h07, 8'h00, "ldn");
		reg_wr(8'h30, 8'hFF);
		chk_rd(8'h30, 8'h01, "act_rd");
		io_check(8'h3C, 1'b1, "io_on");
		reg_wr(8'h30, 8'hFE);
		io_check(8'h3C, 1'b0, "io_off");
		for (int s = 0; s < 2; s++) begin
			reg_wr(8'h31, {7'h7F, s[0]});
			chk_rd(8'h31, {6'h00, 1'b1, s[0]}, "rchk_rd");
			io_check(s ? 8'h55 : 8'hAA, 1'b1, "pattern");
		end
		reg_wr(8'h30, 8'h01);
		reg_wr(8'h38, 8'h3C);
		chk("pdr_cfg", 8'h3C, pdr);
		step;
		ind_we = 1'b1;
		ind_d = 8'hC3;
		step;
		ind_we = 1'b0;
		chk_rd(8'h38, 8'hC3, "pdr_ind");
		reg_wr(8'h02, 8'h01);
		chk("act_ctl", 8'h00, {7'h00, act});
		chk_rd(8'h31, 8'h00, "rchk_ctl");
		chk("pdr_ctl", 8'h00, pdr);
		chk("csn_ctl", 8'h01, card_select_value);
	endtask : sc_regs

	task automatic sc_res;
		// identifier phase lies before; reads start after a wake
		reg_wr(8'h03, 8'h00);
		chk_rd(8'h06, 8'h00, "rd_sleep2");
		reg_wr(8'h03, 8'h01);
		ptr = 0;
		rom_delay = 4'h0;
		res_get;
		res_get;
		rom_delay = 4'h6;
		res_get;
		chk_rd(8'h04, 8'(ptr - 1) ^ 8'hA5, "res_early");
		res_get;
		res_get;
	endtask : sc_res

	// Main sequence
	initial begin
		rstn = 1'b0;
		{addr_wr, data_wr, data_rd, key_ok, iso_lost} = 5'h00;
		{ind_we, io_rd} = 2'h0;
		wdata = 8'h00;
		ind_d = 8'h00;
		io_din = 8'h00;
		rom_delay = 4'h0;
		err_count = 0;
		total_checks = 0;
		ptr = 0;
		repeat (2) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		sc_reset;
		sc_sleep;
		sc_isolate;
		sc_wake;
		sc_regs;
		sc_res;
		final_report;
	end
endmodule : tb_top
